// *** inc/tf_pkg.sv ***
// Shared constants and carrier types for the dual-bank transversal filter.
package tf_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int TAPS = 32;
	localparam int BANKS = 2;
	localparam int COEF_W = 16;
	localparam int SAMPLE_W = 16;
	localparam int PROD_W = 32;
	localparam int ACC_W = 40;
	localparam int ADDR_W = 5;
	localparam int BUF_DEPTH = 2;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;
	localparam logic [COEF_W-1:0] COEF_RST = 16'h0000;
	localparam logic SWAP_REQ_RST = 1'b0;

	// ****************************************
	// Types
	// ****************************************
	typedef logic signed [COEF_W-1:0] coef_t;
	typedef logic signed [SAMPLE_W-1:0] sample_t;
	typedef logic signed [PROD_W-1:0] prod_t;
	typedef logic signed [ACC_W-1:0] acc_t;
	typedef logic [ADDR_W-1:0] addr_t;

	typedef enum logic {
		BANK_A = 1'b0,
		BANK_B = 1'b1
	} bank_e;

	typedef struct packed {
		logic wr;
		logic rd;
		addr_t addr;
		coef_t wdata;
	} host_req_s;

	typedef struct packed {
		sample_t data;
		acc_t cascade;
	} sample_in_s;

	localparam bank_e BANK_RST = BANK_A;

endpackage : tf_pkg

// *** hdl/result_fifo.sv ***
// Small first-in first-out buffer holding filter results until taken.
`timescale 1ns/1ps
module result_fifo #(
	parameter int WIDTH = tf_pkg::ACC_W,
	parameter int DEPTH = tf_pkg::BUF_DEPTH
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import tf_pkg::*;

	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic in_ready_q;
	logic out_valid_q;
	logic push;
	logic pop;
	logic [CW-1:0] wr_idx;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		push = in_valid && in_ready_q;
		pop = out_valid_q && out_ready;
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
		wr_idx = pop ? cnt_q - 1'b1 : cnt_q;
		for (int i = 0; i < DEPTH; i++) begin
			if (pop && i < DEPTH - 1) begin
				mem_d[i] = mem_q[i + 1];
			end else begin
				mem_d[i] = mem_q[i];
			end
			if (push && wr_idx == CW'(i)) begin
				mem_d[i] = in_data;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			in_ready_q <= 1'b1;
			out_valid_q <= 1'b0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			cnt_q <= cnt_d;
			in_ready_q <= cnt_d != FULL;
			out_valid_q <= cnt_d != '0;
			mem_q <= mem_d;
		end
	end

	assign in_ready = in_ready_q;
	assign out_valid = out_valid_q;
	assign out_data = mem_q[0];

	// ****************************************
	// Checks
	// ****************************************
	a_hold_output: assert property (@(posedge mclk) disable iff (!rst_n)
		out_valid_q && !out_ready |=> out_valid_q && $stable(out_data))
		else $error("Result changed while stalled.");
	a_full_refuses: assert property (@(posedge mclk) disable iff (!rst_n)
		!in_ready_q |-> cnt_q == FULL)
		else $error("Buffer refused while not full.");

endmodule : result_fifo

// *** hdl/coef_banks.sv ***
// Two coefficient banks: one feeds the array, the other serves the host.
`timescale 1ns/1ps
module coef_banks (
	input wire logic mclk,
	input wire logic rst_n,
	input wire tf_pkg::bank_e use_bank,
	input wire tf_pkg::bank_e host_bank,
	input wire tf_pkg::host_req_s req,
	output tf_pkg::coef_t host_rdata,
	output tf_pkg::coef_t coef [tf_pkg::TAPS]
);
	import tf_pkg::*;

	coef_t mem_q [BANKS][TAPS];
	coef_t mem_d [BANKS][TAPS];
	coef_t rdata_q;
	coef_t rdata_d;

	// ****************************************
	// Host access to the idle bank
	// ****************************************
	always_comb begin
		mem_d = mem_q;
		rdata_d = rdata_q;
		if (req.wr) begin
			mem_d[host_bank][req.addr] = req.wdata;
		end
		if (req.rd) begin
			rdata_d = mem_q[host_bank][req.addr];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_q <= COEF_RST;
			for (int b = 0; b < BANKS; b++) begin
				for (int t = 0; t < TAPS; t++) begin
					mem_q[b][t] <= COEF_RST;
				end
			end
		end else begin
			rdata_q <= rdata_d;
			mem_q <= mem_d;
		end
	end

	// ****************************************
	// Active bank to the array
	// ****************************************
	always_comb begin
		for (int t = 0; t < TAPS; t++) begin
			coef[t] = mem_q[use_bank][t];
		end
	end

	assign host_rdata = rdata_q;

	a_host_write: assert property (@(posedge mclk) disable iff (!rst_n)
		req.wr |=> mem_q[$past(host_bank)][$past(req.addr)]
			== $past(req.wdata))
		else $error("Host write did not reach the idle bank.");

endmodule : coef_banks

// *** hdl/dual_bank_transversal_filter.sv ***
// Transversal filter core with 32 stages and two swappable coefficient banks.
// Functional notes
// - Two banks, 32 words of 16 bits.
// - One bank computes; host reaches the other.
// - Exchange request swaps banks next computation.
// - Device clears exchange request after swapping.
// - No further swaps until request again.
// - Alternating mode swaps banks every computation.
// - Alternating: even and odd cycles use banks.
// - Chain of 32 multiply-accumulate stages.
// - Correlation: zero, partial pairs, then full.
// - Up to 15 complex points per device.
// - Devices chain directly, same input stream.
`timescale 1ns/1ps
module dual_bank_transversal_filter (
	input wire logic mclk,
	input wire logic rst_n,
	input wire tf_pkg::host_req_s host_req,
	output tf_pkg::coef_t host_rdata,
	input wire logic swap_req,
	input wire logic alt_mode,
	output logic swap_pending,
	output tf_pkg::bank_e active_bank,
	input wire logic sample_valid,
	output logic sample_ready,
	input wire tf_pkg::sample_in_s sample_in,
	output tf_pkg::acc_t cascade_out,
	output logic result_valid,
	input wire logic result_ready,
	output tf_pkg::acc_t result_data
);
	import tf_pkg::*;

	// ****************************************
	// Arithmetic
	// ****************************************
	function automatic acc_t mac(input acc_t a, input coef_t c,
		input sample_t x);
		prod_t p;
		p = c * x;
		return a + ACC_W'(p);
	endfunction : mac

	// ****************************************
	// Declarations
	// ****************************************
	bank_e active_q;
	bank_e active_d;
	logic swap_req_q;
	logic swap_req_d;
	bank_e use_bank;
	bank_e host_bank;
	logic fire;
	logic buf_ready;
	acc_t acc_q [TAPS];
	acc_t acc_d [TAPS];
	coef_t coef [TAPS];
	bank_e last_bank_q;
	bank_e last_bank_d;
	logic last_alt_q;
	logic last_alt_d;

	// A computation cycle runs when a sample is offered and the result
	// buffer has room, so a stalled receiver holds the input back.
	assign fire = sample_valid && buf_ready;

	// ****************************************
	// Bank selection
	// ****************************************
	always_comb begin
		if (alt_mode) begin
			use_bank = active_q;
		end else if (swap_req_q) begin
			use_bank = bank_e'(~active_q);
		end else begin
			use_bank = active_q;
		end
		host_bank = bank_e'(~use_bank);
		active_d = active_q;
		swap_req_d = swap_req_q;
		if (fire) begin
			if (alt_mode) begin
				active_d = bank_e'(~active_q);
			end else begin
				active_d = use_bank;
				swap_req_d = 1'b0;
			end
		end
		if (swap_req) begin
			swap_req_d = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			active_q <= BANK_RST;
			swap_req_q <= SWAP_REQ_RST;
		end else begin
			active_q <= active_d;
			swap_req_q <= swap_req_d;
		end
	end

	// ****************************************
	// Coefficient storage
	// ****************************************
	coef_banks u_banks (
		.mclk(mclk),
		.rst_n(rst_n),
		.use_bank(use_bank),
		.host_bank(host_bank),
		.req(host_req),
		.host_rdata(host_rdata),
		.coef(coef)
	);

	// ****************************************
	// Multiply-accumulate chain
	// ****************************************
	// Every stage sees the same sample; partial sums move one stage toward
	// the output each computation cycle. The far end takes the sum of the next device,
	// so devices join with no glue and share one input stream. With the
	// state flushed by zero samples, the first result of an interleaved
	// correlation is zero and partial pairs precede full ones.
	always_comb begin
		for (int k = 0; k < TAPS; k++) begin
			acc_d[k] = acc_q[k];
			if (fire) begin
				if (k == TAPS - 1) begin
					acc_d[k] = mac(sample_in.cascade, coef[k],
						sample_in.data);
				end else begin
					acc_d[k] = mac(acc_q[k + 1], coef[k],
						sample_in.data);
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int k = 0; k < TAPS; k++) begin
				acc_q[k] <= ACC_RST;
			end
		end else begin
			acc_q <= acc_d;
		end
	end

	// ****************************************
	// Result buffer
	// ****************************************
	result_fifo #(
		.WIDTH(ACC_W),
		.DEPTH(BUF_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(fire),
		.in_ready(buf_ready),
		.in_data(acc_d[0]),
		.out_valid(result_valid),
		.out_ready(result_ready),
		.out_data(result_data)
	);

	assign sample_ready = buf_ready;
	assign cascade_out = acc_q[0];
	assign swap_pending = swap_req_q;
	assign active_bank = active_q;

	// ****************************************
	// Check helpers
	// ****************************************
	always_comb begin
		last_bank_d = last_bank_q;
		last_alt_d = last_alt_q;
		if (fire) begin
			last_bank_d = use_bank;
			last_alt_d = alt_mode;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			last_bank_q <= BANK_RST;
			last_alt_q <= 1'b0;
		end else begin
			last_bank_q <= last_bank_d;
			last_alt_q <= last_alt_d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	a_req_taken: assert property (
		swap_req |=> swap_req_q)
		else $error("Exchange request was lost.");
	a_oneshot_swap: assert property (
		fire && swap_req_q && !alt_mode |=> active_q != $past(active_q))
		else $error("Requested exchange did not swap banks.");
	a_req_self_clear: assert property (
		fire && swap_req_q && !alt_mode && !swap_req |=> !swap_req_q)
		else $error("Exchange request not cleared by device.");
	a_no_extra_swap: assert property (
		fire && !swap_req_q && !alt_mode |=> $stable(active_q))
		else $error("Bank swapped without a request.");
	a_idle_holds: assert property (
		!fire |=> $stable(active_q))
		else $error("Bank changed outside a computation cycle.");
	a_alt_toggles: assert property (
		fire && alt_mode |=> active_q != $past(active_q) ##1 1'b1)
		else $error("Alternating mode did not swap banks.");
	a_alt_parity: assert property (
		fire && alt_mode && last_alt_q |-> use_bank != last_bank_q)
		else $error("Consecutive cycles used the same bank.");
	a_alt_wins: assert property (
		fire && alt_mode && swap_req_q |-> use_bank == active_q)
		else $error("Pending request added a swap in alternating mode.");
	a_host_other_bank: assert property (
		host_bank != use_bank)
		else $error("Host reached the computing bank.");

endmodule : dual_bank_transversal_filter

// *** bench/stream_source.sv ***
// Sample source model that offers samples to the filter core.
`timescale 1ns/1ps
module stream_source (
	input wire logic mclk,
	input wire logic sample_ready,
	output logic sample_valid,
	output tf_pkg::sample_in_s sample_in
);
	import tf_pkg::*;
	// ********
	// Source
	// ********
	initial begin
		sample_valid = 1'b0;
		sample_in = '0;
	end
	// Holds a sample until taken, then shows the inverse of it.
	task send(input sample_t x);
		@(posedge mclk);
		sample_valid <= 1'b1;
		sample_in <= '{data: x, cascade: ACC_RST};
		do @(posedge mclk); while (sample_ready !== 1'b1);
		sample_valid <= 1'b0;
		sample_in <= '{data: ~x, cascade: ~ACC_RST};
	endtask : send
	task flush(input int n);
		repeat (n) send('0);
	endtask : flush
endmodule : stream_source

// *** bench/tb_dual_bank_transversal_filter.sv ***
// Self-checking testbench for the dual-bank transversal filter.
`timescale 1ns/1ps
module tb_dual_bank_transversal_filter;
	import tf_pkg::*;
	logic mclk;
	logic rst_n;
	host_req_s host_req;
	coef_t host_rdata;
	logic swap_req;
	logic alt_mode;
	logic swap_pending;
	bank_e active_bank;
	logic sample_valid;
	logic sample_ready;
	sample_in_s sample_in;
	acc_t cascade_out;
	logic result_valid;
	logic result_ready;
	acc_t result_data;
	int err_total;
	int comparisons;
	dual_bank_transversal_filter u_dual_bank_transversal_filter (
		.mclk(mclk), .rst_n(rst_n), .host_req(host_req),
		.host_rdata(host_rdata), .swap_req(swap_req), .alt_mode(alt_mode),
		.swap_pending(swap_pending), .active_bank(active_bank),
		.sample_valid(sample_valid), .sample_ready(sample_ready),
		.sample_in(sample_in), .cascade_out(cascade_out),
		.result_valid(result_valid), .result_ready(result_ready),
		.result_data(result_data)
	);
	stream_source u_stream_source (
		.mclk(mclk), .sample_ready(sample_ready),
		.sample_valid(sample_valid), .sample_in(sample_in)
	);
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// ********
	// Tasks
	// ********
	task final_report();
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	task chk(input string n, input logic [ACC_W-1:0] e, s);
		comparisons++;
		if (e !== s) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wr(input addr_t a, input coef_t d);
		@(posedge mclk);
		host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		host_req <= '0;
	endtask : wr
	task rd(input addr_t a, input coef_t e);
		@(posedge mclk);
		host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge mclk);
		host_req <= '0;
		@(posedge mclk);
		chk("host_rdata", ACC_W'(e), ACC_W'(host_rdata));
	endtask : rd
	task step(input sample_t x, input acc_t e);
		u_stream_source.send(x);
		@(posedge mclk);
		chk("result_valid", 1'b1, result_valid);
		chk("result_data", e, result_data);
	endtask : step
	task pulse_swap();
		@(posedge mclk);
		swap_req <= 1'b1;
		@(posedge mclk);
		swap_req <= 1'b0;
		@(posedge mclk);
		chk("swap_pending", 1'b1, swap_pending);
	endtask : pulse_swap
	task test_reset();
		chk("sample_ready", 1'b1, sample_ready);
		chk("result_valid", 1'b0, result_valid);
		chk("swap_pending", 1'b0, swap_pending);
		chk("active_bank", BANK_A, active_bank);
		chk("cascade_out", ACC_RST, cascade_out);
		chk("result_data", ACC_RST, result_data);
		chk("host_rdata", ACC_W'(COEF_RST), ACC_W'(host_rdata));
	endtask : test_reset
	task test_one_shot();
		u_stream_source.flush(2);
		for (int k = 0; k < TAPS; k++)
			wr(addr_t'(k), coef_t'(k + 1));
		rd(addr_t'(TAPS - 1), coef_t'(TAPS));
		pulse_swap();
		for (int n = 0; n < TAPS; n++)
			step(sample_t'(n == 0), acc_t'(n + 1));
		chk("active_bank", BANK_B, active_bank);
		chk("swap_pending", 1'b0, swap_pending);
		rd(addr_t'(0), COEF_RST);
		u_stream_source.flush(3);
		chk("active_bank", BANK_B, active_bank);
	endtask : test_one_shot
	task test_stall();
		@(posedge mclk);
		result_ready <= 1'b0;
		u_stream_source.send('0);
		u_stream_source.send('0);
		@(posedge mclk);
		chk("sample_ready", 1'b0, sample_ready);
		chk("result_valid", 1'b1, result_valid);
		result_ready <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("result_valid", 1'b0, result_valid);
		chk("sample_ready", 1'b1, sample_ready);
	endtask : test_stall
	task test_alternate();
		for (int k = 0; k < TAPS; k++)
			wr(addr_t'(k), coef_t'(16'h0100 + k));
		@(posedge mclk);
		alt_mode <= 1'b1;
		pulse_swap();
		for (int n = 0; n < 8; n++) begin
			step(sample_t'(n == 1),
				(n == 0) ? ACC_RST : acc_t'(16'h0100 + n - 1));
			chk("active_bank", n[0] ? BANK_B : BANK_A, active_bank);
		end
		chk("swap_pending", 1'b1, swap_pending);
		@(posedge mclk);
		alt_mode <= 1'b0;
		u_stream_source.flush(1);
		@(posedge mclk);
		chk("active_bank", BANK_A, active_bank);
		chk("swap_pending", 1'b0, swap_pending);
	endtask : test_alternate
	// ********
	// Sequence
	// ********
	initial begin
		err_total = 0;
		comparisons = 0;
		rst_n = 1'b0;
		host_req = '0;
		swap_req = 1'b0;
		alt_mode = 1'b0;
		result_ready = 1'b1;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		test_reset();
		test_one_shot();
		test_stall();
		test_alternate();
		final_report();
	end
	initial begin
		repeat (5000) @(posedge mclk);
		err_total++;
		final_report();
	end
endmodule : tb_dual_bank_transversal_filter
